/* hdl/ubg_pkg.sv */
package ubg_pkg;

  // clock
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned CLK_FREQ_MHZ   = 1000 / CLK_PERIOD_NS;

  // register byte addresses
  localparam logic [15:0] ADDR_BAUD_DIV  = 16'hff93;
  localparam logic [15:0] ADDR_RX_STATUS = 16'hff94;
  localparam logic [15:0] ADDR_TX_STATUS = 16'hff95;

  // reset values
  localparam logic [7:0]  BAUD_DIV_RST   = 8'h00;
  localparam logic [7:0]  RX_STATUS_RST  = 8'h00;
  localparam logic [7:0]  TX_STATUS_RST  = 8'h00;
  localparam logic [7:0]  RDATA_RST      = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ  = 8'h00;
  localparam logic [7:0]  TX_BUF_RST     = 8'hff;

  // receive_error_status field positions
  localparam int unsigned RXS_MPR_BIT    = 3;
  localparam int unsigned RXS_PE_BIT     = 2;
  localparam int unsigned RXS_FE_BIT     = 1;
  localparam int unsigned RXS_OVE_BIT    = 0;

  // transmit_status field positions
  localparam int unsigned TXS_BF_BIT     = 1;
  localparam int unsigned TXS_SF_BIT     = 0;

  // serial_mode_reg field positions
  localparam int unsigned SMR_POWER_BIT  = 7;
  localparam int unsigned SMR_TXE_BIT    = 6;
  localparam int unsigned SMR_RXE_BIT    = 5;
  localparam int unsigned SMR_PS_HI      = 4;
  localparam int unsigned SMR_PS_LO      = 3;

  // transfer_mode_reg field positions and codes
  localparam int unsigned TMR_MODE_HI    = 7;
  localparam int unsigned TMR_MODE_LO    = 6;
  localparam logic [1:0]  MODE_MULTIPROC = 2'h1;

  // clock_select_reg field positions
  localparam int unsigned CSR_TPS_HI     = 6;
  localparam int unsigned CSR_TPS_LO     = 4;
  localparam logic [2:0]  TPS_EXTERNAL   = 3'h0;

  // parity settings
  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_ZERO = 2'h1,
    PAR_ODD  = 2'h2,
    PAR_EVEN = 2'h3
  } ubg_parity_t;

  // baud divisor limits
  localparam logic [7:0]  DIV_K_MIN      = 8'h08;
  localparam logic [7:0]  KCNT_ONE       = 8'h01;
  localparam logic [7:0]  PRE_ONE        = 8'h01;
  localparam logic [6:0]  PRE_RST        = 7'h00;

  // receive buffer
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned RX_FIFO_DEPTH  = 16;

endpackage

/* hdl/ubg_fifo_if.sv */
`timescale 1ns/1ns
interface ubg_fifo_if #(
  parameter int unsigned WIDTH = 8
);
  logic             push_valid;
  logic             push_ready;
  logic [WIDTH-1:0] push_data;
  logic             pop_valid;
  logic             pop_ready;
  logic [WIDTH-1:0] pop_data;
  logic             flush;

  modport fifo (
    input  push_valid,
    input  push_data,
    input  pop_ready,
    input  flush,
    output push_ready,
    output pop_valid,
    output pop_data
  );

  modport user (
    output push_valid,
    output push_data,
    output pop_ready,
    output flush,
    input  push_ready,
    input  pop_valid,
    input  pop_data
  );
endinterface

/* hdl/ubg_fifo.sv */
`timescale 1ns/1ns
module ubg_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // data path
  ubg_fifo_if.fifo  port_io
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0]   CNT_ZERO = '0;
  localparam logic [AW:0]   CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] PTR_ONE  = AW'(1);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q, wr_ptr_d;
  logic [AW-1:0]    rd_ptr_q, rd_ptr_d;
  logic [AW:0]      count_q, count_d;
  logic             full_q, full_d;
  logic             valid_q, valid_d;
  logic [WIDTH-1:0] rdata_q, rdata_d;
  logic             push, pop;

  assign push               = port_io.push_valid & ~full_q & ~port_io.flush;
  assign pop                = port_io.pop_ready & valid_q & ~port_io.flush;
  assign port_io.push_ready = ~full_q;
  assign port_io.pop_valid  = valid_q;
  assign port_io.pop_data   = rdata_q;

  always_comb begin
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    count_d  = count_q;
    if (port_io.flush) begin
      wr_ptr_d = '0;
      rd_ptr_d = '0;
      count_d  = CNT_ZERO;
    end else begin
      if (push) begin
        wr_ptr_d = (wr_ptr_q == PTR_LAST) ? '0 : wr_ptr_q + PTR_ONE;
      end
      if (pop) begin
        rd_ptr_d = (rd_ptr_q == PTR_LAST) ? '0 : rd_ptr_q + PTR_ONE;
      end
      count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
    full_d  = (count_d == CNT_FULL);
    valid_d = (count_d != CNT_ZERO);
    // bypass the array so a word pushed into an empty buffer shows next cycle
    // an empty buffer keeps its last head, so unwritten entries never reach the port
    rdata_d = rdata_q;
    if (push && (wr_ptr_q == rd_ptr_d)) begin
      rdata_d = port_io.push_data;
    end else if (valid_d) begin
      rdata_d = mem_q[rd_ptr_d];
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= port_io.push_data;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= CNT_ZERO;
      full_q   <= 1'b0;
      valid_q  <= 1'b0;
      rdata_q  <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q  <= count_d;
      full_q   <= full_d;
      valid_q  <= valid_d;
      rdata_q  <= rdata_d;
    end
  end
endmodule

/* hdl/ubg_top.sv */
`timescale 1ns/1ns
module ubg_top (
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RESET_N_I,
  // cpu register port
  input  wire logic [15:0] ADDR_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  input  wire logic [7:0]  WDATA_I,
  output logic      [7:0]  RDATA_O,
  // mode registers held elsewhere
  input  wire logic [7:0]  SERIAL_MODE_REG_I,
  input  wire logic [7:0]  TRANSFER_MODE_REG_I,
  input  wire logic [7:0]  CLOCK_SELECT_REG_I,
  input  wire logic        EXT_CLK_I,
  // receive shifter side
  input  wire logic        RX_FRAME_I,
  input  wire logic [7:0]  RX_DATA_I,
  input  wire logic        RX_PARITY_BIT_I,
  input  wire logic        RX_MP_BIT_I,
  input  wire logic        RX_STOP_BIT_I,
  // receive buffer
  input  wire logic        RX_READ_I,
  output logic      [7:0]  RX_DATA_O,
  output logic             RX_VALID_O,
  // transmit buffer and shifter
  input  wire logic        TX_WRITE_I,
  input  wire logic [7:0]  TX_DATA_I,
  input  wire logic        TX_SHIFT_DONE_I,
  output logic             TX_SHIFT_LOAD_O,
  output logic      [7:0]  TX_SHIFT_DATA_O,
  // baud output
  output logic             BAUD_CLK_O,
  output logic             BAUD_TICK_O
);

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  // decoded mode fields
  logic                power_en, tx_en, rx_en, mp_mode;
  ubg_pkg::ubg_parity_t par_set;
  logic [2:0]          src_sel;

  assign power_en = SERIAL_MODE_REG_I[ubg_pkg::SMR_POWER_BIT];
  assign tx_en    = SERIAL_MODE_REG_I[ubg_pkg::SMR_TXE_BIT];
  assign rx_en    = SERIAL_MODE_REG_I[ubg_pkg::SMR_RXE_BIT];
  assign par_set  = ubg_pkg::ubg_parity_t'(SERIAL_MODE_REG_I[ubg_pkg::SMR_PS_HI:ubg_pkg::SMR_PS_LO]);
  assign mp_mode  = (TRANSFER_MODE_REG_I[ubg_pkg::TMR_MODE_HI:ubg_pkg::TMR_MODE_LO] == ubg_pkg::MODE_MULTIPROC);
  assign src_sel  = CLOCK_SELECT_REG_I[ubg_pkg::CSR_TPS_HI:ubg_pkg::CSR_TPS_LO];

  // ---------------- receive buffer fifo
  ubg_fifo_if #(.WIDTH(ubg_pkg::DATA_W)) rx_if ();

  ubg_fifo #(
    .WIDTH (ubg_pkg::DATA_W),
    .DEPTH (ubg_pkg::RX_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i   (CLK_I),
    .rst_n_i (RESET_N_I),
    .port_io (rx_if.fifo)
  );

  logic frame_ok;
  assign frame_ok = RX_FRAME_I & power_en & rx_en;

  // full buffer refuses the byte, it is dropped
  assign rx_if.push_valid = frame_ok;
  assign rx_if.push_data  = RX_DATA_I;
  assign rx_if.pop_ready  = RX_READ_I;
  assign rx_if.flush      = ~power_en;
  assign RX_DATA_O        = rx_if.pop_data;
  assign RX_VALID_O       = rx_if.pop_valid;

  // ---------------- receive error status
  logic mpr_q, mpr_d, pe_q, pe_d, fe_q, fe_d, ove_q, ove_d;
  logic par_odd;

  assign par_odd = ^{RX_DATA_I, RX_PARITY_BIT_I};

  always_comb begin
    mpr_d = mpr_q;
    pe_d  = pe_q;
    fe_d  = fe_q;
    ove_d = ove_q;
    if (!power_en) begin
      mpr_d = 1'b0;
      pe_d  = 1'b0;
      fe_d  = 1'b0;
      ove_d = 1'b0;
    end else if (frame_ok) begin
      if (mp_mode) begin
        mpr_d = RX_MP_BIT_I;
      end
      case (par_set)
        ubg_pkg::PAR_ODD:  pe_d = ~par_odd;
        ubg_pkg::PAR_EVEN: pe_d = par_odd;
        default:           pe_d = 1'b0;
      endcase
      fe_d  = ~RX_STOP_BIT_I;
      ove_d = ~rx_if.push_ready;
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      mpr_q <= ubg_pkg::RX_STATUS_RST[ubg_pkg::RXS_MPR_BIT];
      pe_q  <= ubg_pkg::RX_STATUS_RST[ubg_pkg::RXS_PE_BIT];
      fe_q  <= ubg_pkg::RX_STATUS_RST[ubg_pkg::RXS_FE_BIT];
      ove_q <= ubg_pkg::RX_STATUS_RST[ubg_pkg::RXS_OVE_BIT];
    end else begin
      mpr_q <= mpr_d;
      pe_q  <= pe_d;
      fe_q  <= fe_d;
      ove_q <= ove_d;
    end
  end

  // ---------------- transmit buffer and status
  logic       occ_q, occ_d, busy_q, busy_d;
  logic       load_q, load_d;
  logic [7:0] txbuf_q, txbuf_d, shdata_q, shdata_d;
  logic       tx_on, move;

  assign tx_on = power_en & tx_en;
  // shifter takes the byte when idle or as it finishes the last one
  assign move  = tx_on & occ_q & (~busy_q | TX_SHIFT_DONE_I);

  always_comb begin
    occ_d    = occ_q;
    busy_d   = busy_q;
    txbuf_d  = txbuf_q;
    shdata_d = shdata_q;
    load_d   = 1'b0;
    if (!tx_on) begin
      occ_d  = 1'b0;
      busy_d = 1'b0;
    end else begin
      if (TX_WRITE_I && !occ_q) begin
        occ_d   = 1'b1;
        txbuf_d = TX_DATA_I;
      end
      if (move) begin
        // clear on move, set on load
        occ_d    = 1'b0;
        busy_d   = 1'b1;
        shdata_d = txbuf_q;
        load_d   = 1'b1;
      end else if (TX_SHIFT_DONE_I) begin
        busy_d = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      occ_q    <= ubg_pkg::TX_STATUS_RST[ubg_pkg::TXS_BF_BIT];
      busy_q   <= ubg_pkg::TX_STATUS_RST[ubg_pkg::TXS_SF_BIT];
      txbuf_q  <= ubg_pkg::TX_BUF_RST;
      shdata_q <= ubg_pkg::TX_BUF_RST;
      load_q   <= 1'b0;
    end else begin
      occ_q    <= occ_d;
      busy_q   <= busy_d;
      txbuf_q  <= txbuf_d;
      shdata_q <= shdata_d;
      load_q   <= load_d;
    end
  end

  assign TX_SHIFT_LOAD_O = load_q;
  assign TX_SHIFT_DATA_O = shdata_q;

  // ---------------- register port
  logic [7:0] div_q, div_d, rdata_q, rdata_d;

  always_comb begin
    div_d   = div_q;
    rdata_d = rdata_q;
    // software keeps this write to stopped periods
    if (WR_I && ADDR_I == ubg_pkg::ADDR_BAUD_DIV) begin
      div_d = WDATA_I;
    end
    if (RD_I) begin
      rdata_d = ubg_pkg::UNMAPPED_READ;
      case (ADDR_I)
        ubg_pkg::ADDR_BAUD_DIV: rdata_d = div_q;
        ubg_pkg::ADDR_RX_STATUS: begin
          rdata_d[ubg_pkg::RXS_MPR_BIT] = mpr_q;
          rdata_d[ubg_pkg::RXS_PE_BIT]  = pe_q;
          rdata_d[ubg_pkg::RXS_FE_BIT]  = fe_q;
          rdata_d[ubg_pkg::RXS_OVE_BIT] = ove_q;
        end
        ubg_pkg::ADDR_TX_STATUS: begin
          rdata_d[ubg_pkg::TXS_BF_BIT] = occ_q;
          rdata_d[ubg_pkg::TXS_SF_BIT] = busy_q;
        end
        default: rdata_d = ubg_pkg::UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      // divisor resets to a prohibited value
      div_q   <= ubg_pkg::BAUD_DIV_RST;
      rdata_q <= ubg_pkg::RDATA_RST;
    end else begin
      div_q   <= div_d;
      rdata_q <= rdata_d;
    end
  end

  assign RDATA_O = rdata_q;

  // ---------------- baud generator
  logic [6:0] pre_q, pre_d;
  logic [7:0] kcnt_q, kcnt_d;
  logic       baud_q, baud_d, btick_q, btick_d, ext_q;
  logic [6:0] pre_mask;
  logic       src_tick, div_run;

  // source is main clock over 2^n for n > 0, or EXT_CLK_I rising edges for n = 0
  assign pre_mask = 7'((ubg_pkg::PRE_ONE << src_sel) - ubg_pkg::PRE_ONE);
  assign src_tick = (src_sel == ubg_pkg::TPS_EXTERNAL) ? (EXT_CLK_I & ~ext_q)
                                                      : ((pre_q & pre_mask) == pre_mask);
  // prohibited divisors hold the divider cleared and the baud clock low
  assign div_run  = power_en & (div_q >= ubg_pkg::DIV_K_MIN);

  always_comb begin
    pre_d   = pre_q + 7'(ubg_pkg::PRE_ONE);
    kcnt_d  = kcnt_q;
    baud_d  = baud_q;
    btick_d = 1'b0;
    if (!div_run) begin
      pre_d  = ubg_pkg::PRE_RST;
      kcnt_d = '0;
      baud_d = 1'b0;
    end else if (src_tick) begin
      // toggle every k source ticks gives /2k
      if (kcnt_q >= div_q - ubg_pkg::KCNT_ONE) begin
        kcnt_d  = '0;
        baud_d  = ~baud_q;
        btick_d = 1'b1;
      end else begin
        kcnt_d = kcnt_q + ubg_pkg::KCNT_ONE;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pre_q   <= ubg_pkg::PRE_RST;
      kcnt_q  <= '0;
      baud_q  <= 1'b0;
      btick_q <= 1'b0;
      ext_q   <= 1'b0;
    end else begin
      pre_q   <= pre_d;
      kcnt_q  <= kcnt_d;
      baud_q  <= baud_d;
      btick_q <= btick_d;
      ext_q   <= EXT_CLK_I;
    end
  end

  assign BAUD_CLK_O  = baud_q;
  assign BAUD_TICK_O = btick_q;

  // ---------------- checks
  a_power_clears_rx: assert property (!power_en |=> {mpr_q, pe_q, fe_q, ove_q} == 4'h0)
    else $error("receive flags not cleared with power off");
  a_zero_par_quiet: assert property (frame_ok && par_set == ubg_pkg::PAR_ZERO |=> !pe_q)
    else $error("parity flagged under zero parity setting");
  a_odd_par_err: assert property (power_en && frame_ok && par_set == ubg_pkg::PAR_ODD |=> pe_q == !$past(par_odd))
    else $error("odd parity check wrong");
  a_overrun_drop: assert property (power_en && frame_ok && !rx_if.push_ready |=> ove_q && $stable(RX_VALID_O))
    else $error("overrun not flagged or byte not dropped");
  a_stop_framing: assert property (power_en && frame_ok |=> fe_q == !$past(RX_STOP_BIT_I))
    else $error("framing flag does not follow stop bit");
  a_mpr_uart_hold: assert property (power_en && !mp_mode |=> $stable(mpr_q))
    else $error("id flag moved outside multiprocessor mode");
  a_occ_on_write: assert property (tx_on && TX_WRITE_I && !occ_q |=> occ_q)
    else $error("buffer occupied not set on write");
  a_load_sets_busy: assert property (move |=> TX_SHIFT_LOAD_O && busy_q && !occ_q ##1 !TX_SHIFT_LOAD_O)
    else $error("load did not set shifter busy");
  a_done_idle: assert property (tx_on && TX_SHIFT_DONE_I && !occ_q |=> !busy_q)
    else $error("shifter busy stuck after last byte");
  a_tx_disable: assert property (!tx_on |=> !occ_q && !busy_q)
    else $error("transmit flags survive disable");
  a_prohibited_div: assert property (!div_run |=> !BAUD_CLK_O && !BAUD_TICK_O)
    else $error("baud runs with prohibited divisor");

endmodule

/* dv/ubg_station.sv */
`timescale 1ns/1ns
module ubg_station (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // received frames handed to the device
  output logic            frame_o,
  output logic [7:0]      data_o,
  output logic            parity_o,
  output logic            mp_o,
  output logic            stop_o,
  // transmit shifter handshake
  input  wire logic       load_i,
  input  wire logic [7:0] load_data_i,
  output logic            done_o
);
  int unsigned hold = 30;
  int unsigned cnt;
  int unsigned n_loads;
  logic [7:0]  last_byte;

  initial begin
    frame_o  = 1'b0;
    data_o   = 8'h00;
    parity_o = 1'b0;
    mp_o     = 1'b0;
    stop_o   = 1'b1;
  end

  task automatic send(input logic [7:0] d, input logic p, input logic m, input logic s);
    frame_o  = 1'b1;
    data_o   = d;
    parity_o = p;
    mp_o     = m;
    stop_o   = s;
    @(posedge clk_i);
    #1;
    // released fields no longer carry the frame
    frame_o  = 1'b0;
    data_o   = ~d;
    parity_o = ~p;
    mp_o     = ~m;
    stop_o   = ~s;
    @(posedge clk_i);
    #1;
  endtask

  // each loaded byte keeps the line busy for hold cycles
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt     = 0;
      n_loads = 0;
      done_o  = 1'b0;
    end else begin
      #1;
      done_o = 1'b0;
      if (load_i) begin
        last_byte = load_data_i;
        n_loads++;
        cnt = hold;
      end else if (cnt != 0) begin
        cnt--;
        done_o = (cnt == 0);
      end
    end
  end
endmodule

/* dv/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  localparam logic [15:0] A_DIV = ubg_pkg::ADDR_BAUD_DIV;
  localparam logic [15:0] A_RX  = ubg_pkg::ADDR_RX_STATUS;
  localparam logic [15:0] A_TX  = ubg_pkg::ADDR_TX_STATUS;

  logic        clk;
  logic        rst_n;
  logic [15:0] addr;
  logic        wr;
  logic        rd;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [7:0]  smr;
  logic [7:0]  tmr;
  logic [7:0]  csr;
  logic        ext_clk;
  logic        rx_frame;
  logic [7:0]  rx_byte;
  logic        rx_par;
  logic        rx_mp;
  logic        rx_stop;
  logic        rx_read;
  logic [7:0]  rx_head;
  logic        rx_valid;
  logic        tx_write;
  logic [7:0]  tx_data;
  logic        tx_done;
  logic        tx_load;
  logic [7:0]  tx_shift;
  logic        baud_clk;
  logic        baud_tick;
  int          fails;
  int          n_tests;

  ubg_top i_dut (
    .CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WR_I(wr), .RD_I(rd), .WDATA_I(wdata),
    .RDATA_O(rdata), .SERIAL_MODE_REG_I(smr), .TRANSFER_MODE_REG_I(tmr), .CLOCK_SELECT_REG_I(csr),
    .EXT_CLK_I(ext_clk), .RX_FRAME_I(rx_frame), .RX_DATA_I(rx_byte), .RX_PARITY_BIT_I(rx_par),
    .RX_MP_BIT_I(rx_mp), .RX_STOP_BIT_I(rx_stop), .RX_READ_I(rx_read), .RX_DATA_O(rx_head),
    .RX_VALID_O(rx_valid), .TX_WRITE_I(tx_write), .TX_DATA_I(tx_data), .TX_SHIFT_DONE_I(tx_done),
    .TX_SHIFT_LOAD_O(tx_load), .TX_SHIFT_DATA_O(tx_shift), .BAUD_CLK_O(baud_clk), .BAUD_TICK_O(baud_tick)
  );

  ubg_station i_stn (
    .clk_i(clk), .rst_n_i(rst_n), .frame_o(rx_frame), .data_o(rx_byte), .parity_o(rx_par),
    .mp_o(rx_mp), .stop_o(rx_stop), .load_i(tx_load), .load_data_i(tx_shift), .done_o(tx_done)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // external source clock, 4 system clocks per period
  initial begin
    ext_clk = 1'b0;
    forever #16 ext_clk = ~ext_clk;
  end

  task automatic complete_run();
    if (fails == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    step();
    wr = 1'b0;
    step();
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input string what);
    addr = a;
    rd   = 1'b1;
    step();
    check(what, {8'h00, rdata}, {8'h00, exp});
    // let an edge pass so a following read never re-raises rd in this time step
    rd = 1'b0;
    step();
  endtask

  task automatic pop();
    rx_read = 1'b1;
    step();
    rx_read = 1'b0;
    step();
  endtask

  task automatic tx_wr(input logic [7:0] d);
    tx_data  = d;
    tx_write = 1'b1;
    step();
    tx_write = 1'b0;
  endtask

  task automatic frame(input logic [7:0] d, input logic p, input logic m, input logic s, input logic [7:0] st);
    i_stn.send(d, p, m, s);
    check("rx head", {8'h00, rx_head}, {8'h00, d});
    rd_chk(A_RX, st, "rx status");
    pop();
  endtask

  task automatic baud_period(input logic [2:0] n, input logic [7:0] k);
    int c;
    int per;
    logic b0;
    smr = 8'h00;
    step();
    csr = {1'b0, n, 4'h0};
    smr = 8'h80;
    // receive and transmit stay off while the divisor changes
    reg_wr(A_DIV, k);
    rd_chk(A_DIV, k, "divisor");
    for (c = 0; c < 3000 && baud_tick !== 1'b1; c++) step();
    // the clock must toggle once per tick
    b0 = ~baud_clk;
    step();
    for (c = 1; c < 3000 && baud_tick !== 1'b1; c++) step();
    per = (n == 3'h0) ? int'(k) * 4 : int'(k) << n;
    check("baud period", 16'(c), 16'(per));
    check("baud clock", {15'h0000, baud_clk}, {15'h0000, b0});
  endtask

  initial begin
    step(90000);
    fails++;
    complete_run();
  end

  initial begin
    ubg_pkg::ubg_parity_t ps;
    logic [7:0]           d;
    logic                 pe;
    int                   i;
    int                   t;
    fails    = 0;
    n_tests  = 0;
    rst_n    = 1'b0;
    addr     = 16'h0000;
    wr       = 1'b0;
    rd       = 1'b0;
    wdata    = 8'h00;
    smr      = 8'h00;
    tmr      = 8'h00;
    csr      = 8'h00;
    rx_read  = 1'b0;
    tx_write = 1'b0;
    tx_data  = 8'h00;
    step(20);
    rst_n = 1'b1;
    step();
    rd_chk(A_RX, 8'h00, "rx status reset");
    rd_chk(A_TX, 8'h00, "tx status reset");
    rd_chk(A_DIV, 8'h00, "divisor reset");
    reg_wr(A_RX, 8'hff);
    rd_chk(A_RX, 8'h00, "rx status read only");
    rd_chk(16'hff96, ubg_pkg::UNMAPPED_READ, "unmapped");
    baud_period(3'h0, 8'h08);
    baud_period(3'h1, 8'h09);
    baud_period(3'h3, 8'hff);
    baud_period(3'h7, 8'h08);
    reg_wr(A_DIV, 8'h07);
    t = 0;
    repeat (300) begin
      step();
      t += int'(baud_tick);
    end
    check("ticks below minimum divisor", 16'(t), 16'h0000);
    check("baud clock below minimum", {15'h0000, baud_clk}, 16'h0000);
    for (i = 0; i < 8; i++) begin
      ps  = ubg_pkg::ubg_parity_t'(i[2:1]);
      smr = {3'b101, ps, 3'b000};
      d   = 8'h35 + 8'(i);
      pe  = (ps == ubg_pkg::PAR_ODD) ? !(^d ^ i[0]) : (ps == ubg_pkg::PAR_EVEN) ? (^d ^ i[0]) : 1'b0;
      frame(d, i[0], 1'b0, i != 5, {5'h00, pe, i == 5, 1'b0});
    end
    smr = 8'ha0;
    frame(8'h11, 1'b0, 1'b1, 1'b1, 8'h00);
    tmr = 8'h40;
    frame(8'h12, 1'b0, 1'b1, 1'b1, 8'h08);
    frame(8'h13, 1'b0, 1'b0, 1'b1, 8'h00);
    for (i = 0; i < 16; i++) i_stn.send(8'(i), 1'b0, 1'b0, 1'b1);
    rd_chk(A_RX, 8'h00, "rx status full");
    i_stn.send(8'hee, 1'b0, 1'b0, 1'b1);
    rd_chk(A_RX, 8'h01, "rx status overrun");
    for (i = 0; i < 16; i++) begin
      check("rx drain", {8'h00, rx_head}, 16'(i));
      pop();
    end
    check("rx empty", {15'h0000, rx_valid}, 16'h0000);
    frame(8'h5a, 1'b0, 1'b0, 1'b1, 8'h00);
    i_stn.send(8'h77, 1'b0, 1'b0, 1'b0);
    rd_chk(A_RX, 8'h02, "rx status framing");
    smr = 8'h00;
    step(2);
    rd_chk(A_RX, 8'h00, "rx status power off");
    check("rx flushed", {15'h0000, rx_valid}, 16'h0000);
    smr = 8'hc0;
    step(2);
    tx_wr(8'hab);
    step(3);
    check("loaded byte", {8'h00, i_stn.last_byte}, 16'h00ab);
    rd_chk(A_TX, 8'h01, "tx status busy");
    tx_wr(8'hcd);
    rd_chk(A_TX, 8'h03, "tx status both");
    step(32);
    rd_chk(A_TX, 8'h01, "tx status chained");
    check("second byte", {8'h00, i_stn.last_byte}, 16'h00cd);
    step(32);
    rd_chk(A_TX, 8'h00, "tx status idle");
    tx_wr(8'hef);
    step(3);
    rd_chk(A_TX, 8'h01, "tx status single");
    tx_wr(8'h34);
    rd_chk(A_TX, 8'h03, "tx status loaded");
    // deliberately abrupt disable with a byte still pending
    smr = 8'h80;
    step(2);
    rd_chk(A_TX, 8'h00, "tx status disabled");
    check("shifter loads", 16'(i_stn.n_loads), 16'h0003);
    complete_run();
  end
endmodule
